// *** core/acc_conv_ctrl.sv ***
// Converter control: clock divide, input selection, pin override, sequencer
`timescale 1ns/1ns
module acc_conv_ctrl
   import acc_pkg::*;
#(
   parameter int NUM_CH = ACC_NUM_CH,                   // Shared analog pins
   parameter int RES_W  = ACC_RES_W                     // Result width
) (
   // Clock, reset, enable
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // Register port
   input  wire logic [ACC_AW-1:0] reg_addr,
   input  wire logic [ACC_DW-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [ACC_DW-1:0] reg_rdata,
   // Trigger events from the PWM block
   input  wire logic              pwm_period_evt,       // Period match flag level
   input  wire logic [2:0]        pwm_duty_evt,         // Duty match flag levels
   // Shared pin control
   input  wire logic [NUM_CH-1:0] pin_pullup_req,       // Software pull-high enables
   input  wire logic [NUM_CH-1:0] pin_dir_out_req,      // Software output directions
   output logic      [NUM_CH-1:0] pin_pullup_en,        // Pull-high after override
   output logic      [NUM_CH-1:0] pin_out_en,           // Output driver after override
   output logic      [NUM_CH-1:0] pin_digital_en,       // Other pin functions allowed
   // Analog input switches
   output logic      [NUM_CH-1:0] analog_channel_pins,  // Per-channel switch closed
   output logic                   amplifier_output_sel, // Amplifier output switch
   output logic                   analog_ground_sel,    // Ground switch
   output logic                   input_floating,       // No source connected
   // Converter core
   output logic                   converter_power_enable,
   output logic                   sample_hold,          // High in the sampling phase
   output logic      [RES_W-1:0]  dac_code,             // Trial code for the comparator
   input  wire logic              cmp_in,               // High when input above trial
   // Status
   output logic                   conversion_busy_flag,
   output logic                   conv_done             // One-cycle end pulse
);

   // ---------------- Register storage ----------------
   logic [7:0]        ctrl0_ff;                         // Start, enable, channel
   logic [7:0]        ctrl1_ff;                         // Source, divide
   logic [7:0]        trig_ff;                          // Trigger setup
   logic [7:0]        trigger_delay_value_ff;           // Delay in system clocks
   logic [NUM_CH-1:0] pinsel_ff;                        // Analog mode per pin
   logic [RES_W-1:0]  result_ff;                        // Last conversion result
   logic [7:0]        rdata_ff;                         // Read data register

   // ---------------- Decoded fields ----------------
   logic       start_bit;                               // Current start bit
   logic [3:0] channel_select;                          // Channel field
   logic [2:0] source_select;                           // Source field
   logic [2:0] conv_clock_divide;                       // Divide field
   logic       trig_delayed;                            // Delayed trigger mode
   logic       dly_en;                                  // Delay function on
   logic       pwm_sel_duty;                            // Duty event selected
   logic [1:0] duty_sel;                                // Which duty event

   assign start_bit         = ctrl0_ff[ACC_C0_START];
   assign converter_power_enable = ctrl0_ff[ACC_C0_EN];
   assign channel_select    = ctrl0_ff[ACC_C0_CH_LO +: 4];
   assign source_select     = ctrl1_ff[ACC_C1_SRC_LO +: 3];
   assign conv_clock_divide = ctrl1_ff[ACC_C1_DIV_LO +: 3];
   assign trig_delayed      = trig_ff[ACC_TR_MODE];
   assign dly_en            = trig_ff[ACC_TR_DLYEN];
   assign pwm_sel_duty      = trig_ff[ACC_TR_PWMSEL];
   assign duty_sel          = trig_ff[ACC_TR_DUTY_LO +: 2];

   // ---------------- Write decode ----------------
   logic wr_ctrl0;                                      // Control zero write
   logic wr_ctrl1;                                      // Control one write
   logic wr_trig;                                       // Trigger write
   logic wr_delay;                                      // Delay write
   logic wr_pin_lo;                                     // Pin select low write
   logic wr_pin_hi;                                     // Pin select high write

   assign wr_ctrl0  = reg_wr && (reg_addr == ACC_REG_CTRL0);
   assign wr_ctrl1  = reg_wr && (reg_addr == ACC_REG_CTRL1);
   assign wr_trig   = reg_wr && (reg_addr == ACC_REG_TRIG);
   assign wr_delay  = reg_wr && (reg_addr == ACC_REG_DELAY);
   assign wr_pin_lo = reg_wr && (reg_addr == ACC_REG_PINSEL_L);
   assign wr_pin_hi = reg_wr && (reg_addr == ACC_REG_PINSEL_H);

   // Control registers; busy bit is not stored here
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl0_ff               <= ACC_RST_REG;
         ctrl1_ff               <= ACC_RST_REG;
         trig_ff                <= ACC_RST_REG;
         trigger_delay_value_ff <= ACC_RST_REG;
      end else if (clk_en) begin
         if (wr_ctrl0) begin
            ctrl0_ff <= {1'b0, reg_wdata[6:5], 1'b0, reg_wdata[3:0]};
         end
         if (wr_ctrl1) begin
            ctrl1_ff <= {reg_wdata[7:5], 2'b00, reg_wdata[2:0]};
         end
         if (wr_trig) begin
            trig_ff <= {reg_wdata[7:5], 3'b000, reg_wdata[1:0]};
         end
         if (wr_delay) begin
            trigger_delay_value_ff <= reg_wdata;
         end
      end
   end

   // Pin function select, low register holds pins 0..7
   genvar gp;
   generate
      for (gp = 0; gp < NUM_CH; gp++) begin : g_pin
         logic pin_wr;                                  // This pin's register written
         logic pin_val;                                 // Written value for this pin
         assign pin_wr  = (gp < 8) ? wr_pin_lo : wr_pin_hi;
         assign pin_val = reg_wdata[gp % 8];
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               pinsel_ff[gp] <= ACC_RST_PIN[0];
            end else if (clk_en && pin_wr) begin
               pinsel_ff[gp] <= pin_val;
            end
         end
         // Analog mode forces the pin away from its digital roles
         assign pin_digital_en[gp] = !pinsel_ff[gp];
         assign pin_pullup_en[gp]  = pin_pullup_req[gp] && !pinsel_ff[gp];
         assign pin_out_en[gp]     = pin_dir_out_req[gp] && !pinsel_ff[gp];
      end
   endgenerate

   // ---------------- Input selection ----------------
   logic src_amp;                                       // Amplifier selected
   logic src_gnd;                                       // Ground selected
   logic src_ext;                                       // External channel selected
   logic ch_valid;                                      // Channel code names a pin

   assign src_amp  = (source_select == ACC_SRC_AMP);
   assign src_gnd  = (source_select == ACC_SRC_GND0) ||
                     (source_select == ACC_SRC_GND1);
   assign src_ext  = !src_amp && !src_gnd;
   assign ch_valid = (channel_select < 4'(NUM_CH));

   // Switches open while unpowered so nothing is joined to a dead input
   assign amplifier_output_sel = converter_power_enable && src_amp;
   assign analog_ground_sel    = converter_power_enable && src_gnd;
   assign input_floating       = converter_power_enable && src_ext && !ch_valid;

   // One switch per channel; code six closes pin six like any other
   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
         assign analog_channel_pins[gc] = converter_power_enable && src_ext &&
                                          (channel_select == 4'(gc));
      end
   endgenerate

   // ---------------- Triggering ----------------
   logic       start_prev_ff;                           // Start bit last cycle
   logic       sw_start;                                // Start bit fell
   logic       pwm_sel_evt;                             // Chosen PWM flag level
   logic       pwm_prev_ff;                             // That flag last cycle
   logic       pwm_rise;                                // Flag went 0 to 1
   logic       dly_pend_ff;                             // Delay count running
   logic [7:0] dly_cnt_ff;                              // Remaining system clocks
   logic       dly_fire;                                // Delay elapsed
   logic       hw_start;                                // Delayed mode start
   logic       start_req;                               // Any start request
   logic       start_ok;                                // Start accepted

   // Start on the high-then-low pattern of the start bit
   assign sw_start    = start_prev_ff && !start_bit && !trig_delayed;
   assign pwm_sel_evt = pwm_sel_duty ? pwm_duty_evt[(duty_sel == 2'b11) ? 2'd2 : duty_sel]
                                     : pwm_period_evt;
   assign pwm_rise    = pwm_sel_evt && !pwm_prev_ff && trig_delayed;
   assign dly_fire    = dly_pend_ff && (dly_cnt_ff == 8'h01);
   // Zero delay or delay off starts at once
   assign hw_start    = dly_fire ||
                        (pwm_rise && (!dly_en || (trigger_delay_value_ff == 8'h00)));
   assign start_req   = sw_start || hw_start;

   // Edge history for both trigger sources
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         start_prev_ff <= 1'b0;
         pwm_prev_ff   <= 1'b0;
      end else if (clk_en) begin
         start_prev_ff <= start_bit;
         pwm_prev_ff   <= pwm_sel_evt;
      end
   end

   // Delay counter in system clocks after the PWM event
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dly_pend_ff <= 1'b0;
         dly_cnt_ff  <= 8'h00;
      end else if (clk_en) begin
         if (pwm_rise && dly_en && (trigger_delay_value_ff != 8'h00)) begin
            dly_pend_ff <= 1'b1;
            dly_cnt_ff  <= trigger_delay_value_ff;
         end else if (dly_fire || !trig_delayed) begin
            dly_pend_ff <= 1'b0;
         end else if (dly_pend_ff) begin
            dly_cnt_ff  <= dly_cnt_ff - 8'h01;
         end
      end
   end

   // ---------------- Sequencer ----------------
   acc_state_t       state_ff;                          // Sequencer state
   acc_state_t       nxt_state;                         // Next state
   logic [3:0]       per_cnt_ff;                        // Periods done in this phase
   logic [3:0]       nxt_per_cnt;                       // Next period count
   logic [RES_W-1:0] sar_ff;                            // Successive approximation code
   logic [RES_W-1:0] nxt_sar;                           // Next code
   logic [RES_W-1:0] trial_bit_ff;                      // Bit under test
   logic             tick;                              // Conversion clock period end
   logic             running;                           // Sequence active
   logic             last_period;                       // Final conversion period ends

   assign running     = (state_ff != ACC_IDLE);
   assign start_ok    = start_req && converter_power_enable && !running;
   assign last_period = (state_ff == ACC_CONVERT) && tick &&
                        (per_cnt_ff == 4'(ACC_CONV_PER - 1));

   // Conversion clock runs only during a conversion
   acc_clk_div #(
      .DIV_W             (3)
   ) u_clk_div (
      .ref_clk           (ref_clk),
      .sys_rst           (sys_rst),
      .clk_en            (clk_en),
      .run               (running),
      .conv_clock_divide (conv_clock_divide),
      .tick              (tick)
   );

   // Keep the trial bit when the comparator says input is higher
   always_comb begin
      nxt_sar = sar_ff;
      if (state_ff == ACC_CONVERT && tick) begin
         nxt_sar = cmp_in ? sar_ff : (sar_ff & ~trial_bit_ff);
         nxt_sar = nxt_sar | (trial_bit_ff >> 1);
      end
   end

   // Phase order and period counts
   always_comb begin
      nxt_state   = state_ff;
      nxt_per_cnt = per_cnt_ff;
      case (state_ff)
         ACC_IDLE: begin
            // Wait for an accepted start
            if (start_ok) begin
               nxt_state   = ACC_SAMPLE;
               nxt_per_cnt = 4'h0;
            end
         end
         ACC_SAMPLE: begin
            // Hold the input for the sampling periods
            if (tick) begin
               if (per_cnt_ff == 4'(ACC_SAMPLE_PER - 1)) begin
                  nxt_state   = ACC_CONVERT;
                  nxt_per_cnt = 4'h0;
               end else begin
                  nxt_per_cnt = per_cnt_ff + 4'h1;
               end
            end
         end
         ACC_CONVERT: begin
            // One result bit per period
            if (last_period) begin
               nxt_state   = ACC_IDLE;
               nxt_per_cnt = 4'h0;
            end else if (tick) begin
               nxt_per_cnt = per_cnt_ff + 4'h1;
            end
         end
         default: begin
            nxt_state   = ACC_IDLE;
            nxt_per_cnt = 4'h0;
         end
      endcase
      // Power off aborts any conversion
      if (!converter_power_enable) begin
         nxt_state   = ACC_IDLE;
         nxt_per_cnt = 4'h0;
      end
   end

   // Sequencer registers
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff     <= ACC_IDLE;
         per_cnt_ff   <= 4'h0;
         sar_ff       <= '0;
         trial_bit_ff <= '0;
      end else if (clk_en) begin
         state_ff   <= nxt_state;
         per_cnt_ff <= nxt_per_cnt;
         if (start_ok) begin
            sar_ff       <= RES_W'(1) << (RES_W - 1);
            trial_bit_ff <= RES_W'(1) << (RES_W - 1);
         end else begin
            sar_ff <= nxt_sar;
            if (state_ff == ACC_CONVERT && tick) begin
               trial_bit_ff <= trial_bit_ff >> 1;
            end
         end
      end
   end

   // Result register, written on the last period, cleared on power off
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_ff <= '0;
      end else if (clk_en) begin
         if (!converter_power_enable) begin
            result_ff <= '0;
         end else if (last_period) begin
            result_ff <= nxt_sar & ~(trial_bit_ff >> 1);
         end
      end
   end

   // Busy follows the sequencer, done marks the final period
   assign conversion_busy_flag = running;
   assign conv_done            = clk_en && last_period;
   assign sample_hold          = (state_ff == ACC_SAMPLE);
   assign dac_code             = sar_ff;

   // ---------------- Read path ----------------
   logic [7:0] rd_mux;                                  // Selected read value

   always_comb begin
      case (reg_addr)
         ACC_REG_CTRL0:    rd_mux = ctrl0_ff | {running, 7'h00};
         ACC_REG_CTRL1:    rd_mux = ctrl1_ff;
         ACC_REG_TRIG:     rd_mux = trig_ff;
         ACC_REG_DELAY:    rd_mux = trigger_delay_value_ff;
         ACC_REG_RES_HI:   rd_mux = {4'h0, result_ff[11:8]};
         ACC_REG_RES_LO:   rd_mux = result_ff[7:0];
         ACC_REG_PINSEL_L: rd_mux = pinsel_ff[7:0];
         ACC_REG_PINSEL_H: rd_mux = {6'h00, pinsel_ff[9:8]};
         default:          rd_mux = 8'h00;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= 8'h00;
      end else if (clk_en) begin
         rdata_ff <= reg_rd ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule // acc_conv_ctrl

// *** core/acc_pkg.sv ***
// Shared constants and types for the converter control block
package acc_pkg;

   // Register bus geometry
   localparam int ACC_AW = 3;                           // Register address width
   localparam int ACC_DW = 8;                           // Register data width

   // Register offsets
   localparam logic [2:0] ACC_REG_CTRL0    = 3'h0;      // converter_control_zero
   localparam logic [2:0] ACC_REG_CTRL1    = 3'h1;      // converter_control_one
   localparam logic [2:0] ACC_REG_TRIG     = 3'h2;      // Trigger configuration
   localparam logic [2:0] ACC_REG_DELAY    = 3'h3;      // trigger_delay_value
   localparam logic [2:0] ACC_REG_RES_HI   = 3'h4;      // result_high
   localparam logic [2:0] ACC_REG_RES_LO   = 3'h5;      // result_low
   localparam logic [2:0] ACC_REG_PINSEL_L = 3'h6;      // pin_function_select_low
   localparam logic [2:0] ACC_REG_PINSEL_H = 3'h7;      // pin_function_select_high

   // Control zero fields
   localparam int ACC_C0_BUSY  = 7;                     // Busy flag, read only
   localparam int ACC_C0_START = 6;                     // Start bit
   localparam int ACC_C0_EN    = 5;                     // Power enable
   localparam int ACC_C0_CH_LO = 0;                     // Channel field, four bits

   // Control one fields
   localparam int ACC_C1_SRC_LO = 5;                    // Source field, three bits
   localparam int ACC_C1_DIV_LO = 0;                    // Divide field, three bits

   // Trigger register fields
   localparam int ACC_TR_MODE   = 7;                    // 0 start bit, 1 delayed trigger
   localparam int ACC_TR_DLYEN  = 6;                    // Delay function enable
   localparam int ACC_TR_PWMSEL = 5;                    // 0 period event, 1 duty event
   localparam int ACC_TR_DUTY_LO = 0;                   // Duty event select, two bits

   // Reset values
   localparam logic [7:0] ACC_RST_REG = 8'h00;          // All registers clear
   localparam logic [9:0] ACC_RST_PIN = 10'h000;        // All pins digital

   // Source select codes
   localparam logic [2:0] ACC_SRC_AMP  = 3'h1;          // Amplifier output
   localparam logic [2:0] ACC_SRC_GND0 = 3'h2;          // Analog ground
   localparam logic [2:0] ACC_SRC_GND1 = 3'h3;          // Analog ground

   // Channel codes
   localparam int         ACC_NUM_CH   = 10;            // Analog channel pins
   localparam logic [3:0] ACC_CH_INT6  = 4'h6;          // Channel six, an ordinary pin
   localparam logic [3:0] ACC_CH_FLOAT = 4'he;          // Floating, as is every code from 10 up

   // Sequence timing in conversion clock periods
   localparam int ACC_SAMPLE_PER = 4;                   // Sampling phase
   localparam int ACC_CONV_PER   = 12;                  // Conversion phase
   localparam int ACC_RES_W      = 12;                  // Result width

   // Sequencer states
   typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT} acc_state_t;

endpackage

// *** core/acc_clk_div.sv ***
// Conversion clock tick generator, power-of-two divider
`timescale 1ns/1ns
module acc_clk_div
   import acc_pkg::*;
#(
   parameter int DIV_W = 3                              // Divide code width
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             clk_en,
   // Control
   input  wire logic             run,                   // Counts only while high
   input  wire logic [DIV_W-1:0] conv_clock_divide,     // Code n divides by 2**n
   // Tick out
   output logic                  tick                   // One cycle per conversion clock
);

   localparam int CNT_W = (1 << DIV_W) - 1;             // Wide enough for largest ratio

   logic [CNT_W-1:0] cnt_ff;                            // Free count within one period
   logic [CNT_W-1:0] nxt_cnt;                           // Next count
   logic [CNT_W-1:0] wrap_mask;                         // Ratio minus one

   // Period end when the low bits of the count are all ones
   assign wrap_mask = CNT_W'((1 << conv_clock_divide) - 1);
   assign tick      = run && ((cnt_ff & wrap_mask) == wrap_mask);
   assign nxt_cnt   = run ? (tick ? '0 : cnt_ff + 1'b1) : '0;

   // Counter, restarts so each conversion sees whole periods
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
      end else if (clk_en) begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule // acc_clk_div

// *** verification/acc_conv_ctrl_props.sv ***
// Port-level assertions for the converter control block
`timescale 1ns/1ns
module acc_conv_ctrl_props
   import acc_pkg::*;
#(parameter int NUM_CH = ACC_NUM_CH) (
   input wire logic              ref_clk, sys_rst, conversion_busy_flag, conv_done, sample_hold,
   input wire logic              amplifier_output_sel, analog_ground_sel, input_floating,
   input wire logic              converter_power_enable,
   input wire logic [NUM_CH-1:0] pin_pullup_req, pin_dir_out_req, pin_pullup_en, pin_out_en,
   input wire logic [NUM_CH-1:0] pin_digital_en, analog_channel_pins
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_pull; pin_pullup_en == (pin_pullup_req & pin_digital_en); endproperty
   a_pull: assert property (p_pull) else $error("pull-high kept on analog pin");
   property p_dir; pin_out_en == (pin_dir_out_req & pin_digital_en); endproperty
   a_dir: assert property (p_dir) else $error("driver kept on analog pin");
   property p_amp; amplifier_output_sel |-> !analog_channel_pins && !analog_ground_sel; endproperty
   a_amp: assert property (p_amp) else $error("amplifier joined to another input");
   property p_gnd; analog_ground_sel |-> !analog_channel_pins && !input_floating; endproperty
   a_gnd: assert property (p_gnd) else $error("ground joined to another input");
   property p_flt; input_floating |-> !analog_channel_pins && !amplifier_output_sel; endproperty
   a_flt: assert property (p_flt) else $error("floating input has a switch closed");
   property p_pwr; !converter_power_enable [*2] |-> !conversion_busy_flag; endproperty
   a_pwr: assert property (p_pwr) else $error("busy while powered down");
   property p_done; conv_done |-> conversion_busy_flag ##1 !conversion_busy_flag; endproperty
   a_done: assert property (p_done) else $error("busy not dropped at end");
   property p_smp; $rose(conversion_busy_flag) |-> sample_hold [*4]; endproperty
   a_smp: assert property (p_smp) else $error("sampling phase too short");
endmodule // acc_conv_ctrl_props
bind acc_conv_ctrl acc_conv_ctrl_props #(.NUM_CH(NUM_CH)) chk_u (.*);

// *** verification/acc_analog_model.sv ***
// Far side model: channel pins, amplifier and ground seen through the comparator
`timescale 1ns/1ns
module acc_analog_model
   import acc_pkg::*;
#(parameter logic [11:0] AMP_LVL = 12'ha5c) (
   input wire logic [ACC_NUM_CH-1:0] analog_channel_pins,
   input wire logic                  amplifier_output_sel, analog_ground_sel, input_floating,
   input wire logic [ACC_RES_W-1:0]  dac_code,
   output logic                      cmp_in
);
   logic [ACC_RES_W-1:0] level;  // Voltage on the joined input node
   always_comb begin
      level = 12'h000;  // Ground or nothing pulls it low
      for (int i = 0; i < ACC_NUM_CH; i++)
         if (analog_channel_pins[i]) level = 12'h137 * 12'(i + 1);
      if (amplifier_output_sel) level = AMP_LVL;
   end
   // Floating node wanders with the trial code
   assign cmp_in = input_floating ? dac_code[0] : (level >= dac_code);
endmodule // acc_analog_model

// *** verification/acc_conv_ctrl_tb.sv ***
// Testbench for the converter control block
`timescale 1ns/1ns
module acc_conv_ctrl_tb;
   import acc_pkg::*;
   logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic pwm_period_evt = 1'b0, cmp_in, amplifier_output_sel, analog_ground_sel, input_floating;
   logic converter_power_enable, sample_hold, conversion_busy_flag, conv_done;
   logic [2:0] reg_addr = 3'h0, pwm_duty_evt = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, b, h;
   logic [9:0] pin_pullup_req = 10'h3ff, pin_dir_out_req = 10'h2aa;
   logic [9:0] pin_pullup_en, pin_out_en, pin_digital_en, analog_channel_pins;
   logic [11:0] dac_code;
   int errors = 0, compares = 0, p, n;
   acc_conv_ctrl dut_u (.*);
   acc_analog_model far_u (.*);
   initial forever #2 ref_clk = ~ref_clk;
   task automatic end_sim;
      $display("counts: %0d compares, %0d errors", compares, errors);
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, exp);
      compares++;
      if (got !== exp) begin errors++; $display("[ERR] %0t got %h want %h", $time, got, exp); end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; @(posedge ref_clk);
      reg_wr <= 1'b0; @(posedge ref_clk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      reg_addr <= a; reg_rd <= 1'b1; @(posedge ref_clk);
      reg_rd <= 1'b0; #1 d = reg_rdata; @(posedge ref_clk);
   endtask
   // Count idle cycles, then busy cycles, with a bound; sampled 1 ns after each edge
   task automatic wt(output int p, n);
      logic bz;
      p = 0; n = 0; bz = 1'b0;
      for (int k = 0; k < 4000 && (n == 0 || bz); k++) begin
         #1 bz = conversion_busy_flag;
         if (bz) n++; else if (n == 0) p++;
         @(posedge ref_clk);
      end
      if (n == 0 || bz) begin
         errors++; $display("[ERR] %0t conversion hang", $time); end_sim();
      end
   endtask
   // Ideal far side accepts any divide; a real input needs the period window
   task automatic run(input logic [2:0] s, d, input logic [3:0] c, input logic [11:0] e);
      wr(ACC_REG_CTRL1, {s, 2'b00, d});
      wr(ACC_REG_CTRL0, {4'h2, c});
      repeat (8) @(posedge ref_clk);
      wr(ACC_REG_CTRL0, {4'h6, c});
      wr(ACC_REG_CTRL0, {4'h2, c});
      wt(p, n);
      chk(12'(n == (16 << d)), 12'h001);
      rd(ACC_REG_RES_HI, h); rd(ACC_REG_RES_LO, b);
      chk({h[3:0], b}, e);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0; @(posedge ref_clk);
      for (int a = 0; a < 8; a++) begin rd(3'(a), b); chk(12'(b), 12'h000); end
      $display("test reset values done");
      wr(ACC_REG_PINSEL_L, 8'h0f);
      wr(ACC_REG_PINSEL_H, 8'h02);
      chk(12'(pin_digital_en), 12'h1f0);
      chk(12'(pin_pullup_en), 12'h1f0);
      chk(12'(pin_out_en), 12'h0a0);
      for (int d = 0; d < 8; d++) run(3'(d < 4 ? 0 : d), 3'(d), 4'(d), 12'h137 * 12'(d + 1));
      $display("test dividers and channels done");
      wr(ACC_REG_CTRL0, 8'h2f);
      chk({input_floating, 1'b0, analog_channel_pins}, 12'h800);
      for (int s = 3; s > 0; s--) run(3'(s), 3'h0, 4'h3, s == 1 ? 12'ha5c : 12'h000);
      wr(ACC_REG_CTRL1, 8'h07); wr(ACC_REG_CTRL0, 8'h61); wr(ACC_REG_CTRL0, 8'h21);
      repeat (20) @(posedge ref_clk);
      rd(ACC_REG_CTRL0, b);
      chk(12'(b), 12'h0a1);
      wr(ACC_REG_CTRL0, 8'h00);
      rd(ACC_REG_RES_LO, b);
      chk({conversion_busy_flag, 3'h0, b}, 12'h000);
      $display("test sources and abort done");
      wr(ACC_REG_TRIG, 8'hc0); wr(ACC_REG_DELAY, 8'h05); wr(ACC_REG_CTRL1, 8'h00);
      wr(ACC_REG_CTRL0, 8'h23); repeat (8) @(posedge ref_clk);
      pwm_period_evt <= 1'b1;
      wt(p, n);
      chk(12'(p), 12'h006);
      $display("test delayed trigger done");
      wr(ACC_REG_DELAY, 8'h00); wr(ACC_REG_TRIG, 8'ha3);
      pwm_duty_evt <= 3'h4;
      wt(p, n);
      chk(12'(p), 12'h001);
      $display("test duty trigger done");
      end_sim();
   end
endmodule // acc_conv_ctrl_tb
